// *** rtl/mpss_low_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// counts how long a synchronous input has stayed low; fires at the limit, then again every LIMIT cycles while it stays low
module mpss_low_timer #(
    parameter int unsigned LIMIT = 32'd250000000,
    parameter int unsigned W = 28
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic arm_i,
    input wire logic level_n_i,
    output logic hit_o
);
    logic [W-1:0] cnt_r, cnt_nxt;
    logic hit_r, hit_nxt;
    logic seen_r, seen_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        hit_nxt = 1'b0;
        // a key held low since before arming never wakes: it must be seen high first
        seen_nxt = arm_i && (seen_r || level_n_i);
        // short pulses restart the count, so they never wake
        if (!arm_i || level_n_i || !seen_r) begin
            cnt_nxt = '0;
        end else if (cnt_r != W'(LIMIT - 1)) begin
            cnt_nxt = cnt_r + W'(1);
        end else begin
            hit_nxt = 1'b1;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
            hit_r <= 1'b0;
            seen_r <= 1'b0;
        end else if (ce_i) begin
            cnt_r <= cnt_nxt;
            hit_r <= hit_nxt;
            seen_r <= seen_nxt;
        end
    end

    assign hit_o = hit_r;
endmodule
`default_nettype wire

// *** rtl/mpss_pkg.sv ***
package mpss_pkg;
    typedef enum logic [2:0] {
        MPSS_OFF, MPSS_BOOT, MPSS_ON, MPSS_SLEEP, MPSS_PSM,
        MPSS_ORDERLY, MPSS_FAST, MPSS_HALT
    } mpss_state_e;
endpackage

// *** rtl/mpss_regs.svh ***
`ifndef MPSS_REGS_SVH
`define MPSS_REGS_SVH
// wake hold time, seconds, and clock rate
`define MPSS_WAKE_MIN_S 5
`define MPSS_CLK_HZ 50000000
`define MPSS_WAKE_MIN_CYC (`MPSS_WAKE_MIN_S * `MPSS_CLK_HZ)
// orderly power-off time, milliseconds (detach plus filesystem close)
`define MPSS_ORDERLY_MS 1000
`define MPSS_ORDERLY_CYC (`MPSS_ORDERLY_MS * (`MPSS_CLK_HZ / 1000))
// fast shutdown: filesystem close only
`define MPSS_FAST_MS 10
`define MPSS_FAST_CYC (`MPSS_FAST_MS * (`MPSS_CLK_HZ / 1000))
// sleep command latency in cycles
`define MPSS_SLEEP_LAT_CYC 16
// power-up settle in cycles
`define MPSS_BOOT_CYC 64
`endif

// *** rtl/mpss_sequencer.sv ***
// Functional notes
// - indicator high whenever module is on; no command lowers it.
// - indicator low in deep sleep, entered only if host enabled it.
// - timer expiry in deep sleep shuts down until wake-up.
// - falling edge on armed fast-shutdown input starts fast shutdown.
// - fast-shutdown command starts the same fast shutdown.
// - off state keeps only the clock; leaves only toward on.
// - on accepts commands at once; sleep accepts after latency.
// - clock runs while supply present; settings lost when removed.
// - key tied low loses wake; shutdown needs command then supply removal.
// - unconditional shutdown resets and halts without detach; not in deep sleep.
// - orderly power-off detaches then closes filesystem, over one second; code raises detach and close together.
// - three-wire SPI port with chip select, master or slave.
`timescale 1ns/1ps
`default_nettype none
`include "mpss_regs.svh"
module mpss_sequencer import mpss_pkg::*; #(
    parameter int unsigned WAKE_CYC = `MPSS_WAKE_MIN_CYC,
    parameter int unsigned ORDERLY_CYC = `MPSS_ORDERLY_CYC,
    parameter int unsigned FAST_CYC = `MPSS_FAST_CYC,
    parameter int unsigned SLEEP_LAT = `MPSS_SLEEP_LAT_CYC,
    parameter int unsigned BOOT_CYC = `MPSS_BOOT_CYC,
    parameter int unsigned RTC_W = 32
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic main_supply_i,
    input wire logic power_key_wake_n_i,
    input wire logic power_on_cmd_i,
    input wire logic shutdown_command_i,
    input wire logic fast_shutdown_command_i,
    input wire logic uncond_shutdown_i,
    input wire logic psm_enable_cmd_i,
    input wire logic sleep_enable_i,
    input wire logic update_timer_expired_i,
    input wire logic sched_wake_i,
    input wire logic fast_gpio_en_i,
    input wire logic fast_gpio_i,
    input wire logic host_cmd_valid_i,
    input wire logic spi_master_i,
    input wire logic spi_cs_cfg_i,
    input wire logic rtc_set_i,
    input wire logic [RTC_W-1:0] rtc_value_i,
    output logic power_on_indicator_o,
    output logic baseband_on_o,
    output logic cmd_accept_o,
    output logic detach_o,
    output logic fs_close_o,
    output logic rtc_run_o,
    output logic [RTC_W-1:0] rtc_count_o,
    output logic spi_en_o,
    output logic spi_master_o,
    output logic spi_cs_ctrl_o,
    output logic [2:0] state_o
);
    localparam int CW = 32;

    mpss_state_e st_r, st_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic psm_en_r, psm_en_nxt;
    logic gpio_q_r, gpio_q_nxt;
    logic pend_r, pend_nxt;
    logic [RTC_W-1:0] rtc_r, rtc_nxt;
    logic ind_r, bb_r, acc_r, det_r, fs_r, rtcr_r, spi_r, spim_r, spics_r;
    logic ind_nxt, bb_nxt, acc_nxt, det_nxt, fs_nxt, rtcr_nxt, spi_nxt;
    logic spim_nxt, spics_nxt;
    logic wake_hit, fast_req, awake;

    // --------------------------------------------------------------
    // wake key filter
    // --------------------------------------------------------------
    mpss_low_timer #(
        .LIMIT(WAKE_CYC),
        .W(CW)
    ) u_wake (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .arm_i(st_r == MPSS_PSM),
        .level_n_i(power_key_wake_n_i),
        .hit_o(wake_hit)
    );

    function automatic logic is_awake(input mpss_state_e s);
        return (s == MPSS_ON) || (s == MPSS_SLEEP);
    endfunction

    // --------------------------------------------------------------
    // state sequencing
    // --------------------------------------------------------------
    always_comb begin
        awake = is_awake(st_r);
        fast_req = (fast_gpio_en_i && gpio_q_r && !fast_gpio_i)
            || fast_shutdown_command_i;
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        psm_en_nxt = psm_en_r;
        pend_nxt = pend_r;
        gpio_q_nxt = fast_gpio_i;
        acc_nxt = 1'b0;
        if (psm_enable_cmd_i && awake) begin
            psm_en_nxt = 1'b1;
        end
        unique case (st_r)
            MPSS_OFF: begin
                // only way out is power-on
                if (power_on_cmd_i) begin
                    st_nxt = MPSS_BOOT;
                    cnt_nxt = '0;
                end
            end
            MPSS_BOOT: begin
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r >= CW'(BOOT_CYC - 1)) begin
                    st_nxt = MPSS_ON;
                end
            end
            MPSS_ON, MPSS_SLEEP: begin
                if (st_r == MPSS_ON) begin
                    acc_nxt = host_cmd_valid_i;
                    if (sleep_enable_i) begin
                        st_nxt = MPSS_SLEEP;
                    end
                end else begin
                    // sleep: latch command, answer after wake latency
                    if (host_cmd_valid_i && !pend_r) begin
                        pend_nxt = 1'b1;
                        cnt_nxt = '0;
                    end else if (pend_r) begin
                        cnt_nxt = cnt_r + CW'(1);
                        if (cnt_r >= CW'(SLEEP_LAT - 1)) begin
                            acc_nxt = 1'b1;
                            pend_nxt = 1'b0;
                        end
                    end
                    if (!sleep_enable_i && !pend_r) begin
                        st_nxt = MPSS_ON;
                    end
                end
                if (psm_en_r && update_timer_expired_i) begin
                    st_nxt = MPSS_PSM;
                    pend_nxt = 1'b0;
                end
                if (shutdown_command_i) begin
                    st_nxt = MPSS_ORDERLY;
                    cnt_nxt = '0;
                    pend_nxt = 1'b0;
                end
                if (fast_req) begin
                    st_nxt = MPSS_FAST;
                    cnt_nxt = '0;
                    pend_nxt = 1'b0;
                end
            end
            MPSS_PSM: begin
                // down until scheduled wake or long key hold
                if (sched_wake_i || wake_hit) begin
                    st_nxt = MPSS_BOOT;
                    cnt_nxt = '0;
                end
            end
            MPSS_ORDERLY: begin
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r >= CW'(ORDERLY_CYC - 1)) begin
                    st_nxt = MPSS_OFF;
                end
            end
            MPSS_FAST: begin
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r >= CW'(FAST_CYC - 1)) begin
                    st_nxt = MPSS_OFF;
                end
            end
            MPSS_HALT: begin
                if (power_on_cmd_i) begin
                    st_nxt = MPSS_BOOT;
                    cnt_nxt = '0;
                end
            end
        endcase
        // emergency exit: no detach, ignored in deep sleep
        if (uncond_shutdown_i && st_r != MPSS_PSM && st_r != MPSS_OFF) begin
            st_nxt = MPSS_HALT;
            pend_nxt = 1'b0;
        end
        if (st_nxt == MPSS_OFF || st_nxt == MPSS_HALT) begin
            psm_en_nxt = 1'b0;
        end
        // supply loss drops everything
        if (!main_supply_i) begin
            st_nxt = MPSS_OFF;
            psm_en_nxt = 1'b0;
            pend_nxt = 1'b0;
            acc_nxt = 1'b0;
        end
    end

    // --------------------------------------------------------------
    // output decode and clock
    // --------------------------------------------------------------
    always_comb begin
        ind_nxt = is_awake(st_nxt) || st_nxt == MPSS_BOOT
            || st_nxt == MPSS_ORDERLY || st_nxt == MPSS_FAST;
        bb_nxt = ind_nxt;
        det_nxt = (st_nxt == MPSS_ORDERLY);
        fs_nxt = (st_nxt == MPSS_ORDERLY) || (st_nxt == MPSS_FAST);
        rtcr_nxt = main_supply_i;
        spi_nxt = is_awake(st_nxt);
        spim_nxt = spi_master_i;
        spics_nxt = spi_cs_cfg_i;
        rtc_nxt = rtc_r;
        if (!main_supply_i) begin
            rtc_nxt = '0;
        end else if (rtc_set_i && is_awake(st_r)) begin
            rtc_nxt = rtc_value_i;
        end else begin
            rtc_nxt = rtc_r + RTC_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= MPSS_OFF;
            cnt_r <= '0;
            psm_en_r <= 1'b0;
            gpio_q_r <= 1'b1;
            pend_r <= 1'b0;
            rtc_r <= '0;
            ind_r <= 1'b0;
            bb_r <= 1'b0;
            acc_r <= 1'b0;
            det_r <= 1'b0;
            fs_r <= 1'b0;
            rtcr_r <= 1'b0;
            spi_r <= 1'b0;
            spim_r <= 1'b0;
            spics_r <= 1'b0;
        end else if (ce_i) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            psm_en_r <= psm_en_nxt;
            gpio_q_r <= gpio_q_nxt;
            pend_r <= pend_nxt;
            rtc_r <= rtc_nxt;
            ind_r <= ind_nxt;
            bb_r <= bb_nxt;
            acc_r <= acc_nxt;
            det_r <= det_nxt;
            fs_r <= fs_nxt;
            rtcr_r <= rtcr_nxt;
            spi_r <= spi_nxt;
            spim_r <= spim_nxt;
            spics_r <= spics_nxt;
        end
    end

    assign power_on_indicator_o = ind_r;
    assign baseband_on_o = bb_r;
    assign cmd_accept_o = acc_r;
    assign detach_o = det_r;
    assign fs_close_o = fs_r;
    assign rtc_run_o = rtcr_r;
    assign rtc_count_o = rtc_r;
    assign spi_en_o = spi_r;
    assign spi_master_o = spim_r;
    assign spi_cs_ctrl_o = spics_r;
    assign state_o = st_r;
endmodule
`default_nettype wire

// *** verif/mpss_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// host side: holds the key low for a count, else the pull-up wins
module mpss_host_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [7:0] hold_i,
    output logic power_key_wake_n_o
);
    logic [7:0] left_r = 8'h00;
    always @(posedge clk_i) begin
        if (go_i) begin
            left_r <= hold_i;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end
    assign power_key_wake_n_o = (left_r == 8'h00);
endmodule
`default_nettype wire

// *** verif/mpss_sequencer_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpss_sequencer_checker import mpss_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic main_supply_i,
    input wire logic shutdown_command_i,
    input wire logic fast_shutdown_command_i,
    input wire logic uncond_shutdown_i,
    input wire logic update_timer_expired_i,
    input wire logic fast_gpio_en_i,
    input wire logic fast_gpio_i,
    input wire logic host_cmd_valid_i,
    input wire logic sleep_enable_i,
    input wire logic power_on_indicator_o,
    input wire logic baseband_on_o,
    input wire logic cmd_accept_o,
    input wire logic detach_o,
    input wire logic fs_close_o,
    input wire logic rtc_run_o,
    input wire logic [2:0] state_o
);
    // --------
    // state rules
    // --------
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic up = state_o inside {MPSS_ON, MPSS_SLEEP};
    wire logic pw = up || state_o inside {MPSS_BOOT, MPSS_ORDERLY, MPSS_FAST};
    wire logic calm = up && ce_i && main_supply_i && !uncond_shutdown_i;
    sequence s_into_psm; up ##1 state_o == MPSS_PSM; endsequence
    sequence s_fast; state_o == MPSS_FAST && fs_close_o && !detach_o; endsequence
    property p_on; pw |-> power_on_indicator_o && baseband_on_o; endproperty
    a_on: assert property (p_on) else $error("indicator low while powered");
    property p_psm; state_o == MPSS_PSM |-> !power_on_indicator_o; endproperty
    a_psm: assert property (p_psm) else $error("indicator high in deep sleep");
    property p_psm_cause; s_into_psm |-> $past(update_timer_expired_i); endproperty
    a_psm_cause: assert property (p_psm_cause) else $error("psm without timer");
    property p_off;
        state_o == MPSS_OFF |-> !baseband_on_o ##1 state_o inside {MPSS_OFF, MPSS_BOOT};
    endproperty
    a_off: assert property (p_off) else $error("bad exit from off");
    property p_gpio; calm && fast_gpio_en_i && $fell(fast_gpio_i) |=> s_fast; endproperty
    a_gpio: assert property (p_gpio) else $error("gpio edge missed");
    property p_fcmd; calm && fast_shutdown_command_i |=> s_fast; endproperty
    a_fcmd: assert property (p_fcmd) else $error("fast command missed");
    property p_orderly;
        calm && shutdown_command_i && !fast_shutdown_command_i && !fast_gpio_en_i
            |=> state_o == MPSS_ORDERLY && detach_o && fs_close_o;
    endproperty
    a_orderly: assert property (p_orderly) else $error("orderly off missed");
    property p_halt;
        up && ce_i && main_supply_i && uncond_shutdown_i
            |=> state_o == MPSS_HALT && !detach_o && !baseband_on_o;
    endproperty
    a_halt: assert property (p_halt) else $error("halt missed");
    property p_halt_psm;
        state_o == MPSS_PSM && ce_i && main_supply_i && uncond_shutdown_i
            |=> state_o != MPSS_HALT;
    endproperty
    a_halt_psm: assert property (p_halt_psm) else $error("halt taken in deep sleep");
    property p_acc;
        calm && state_o == MPSS_ON && host_cmd_valid_i && !sleep_enable_i && !fast_gpio_en_i
            && !shutdown_command_i && !fast_shutdown_command_i && !update_timer_expired_i
            |=> cmd_accept_o;
    endproperty
    a_acc: assert property (p_acc) else $error("command not taken at once");
    property p_rtc;
        $past(ce_i) && !$past(sys_rst_i) |-> rtc_run_o == $past(main_supply_i);
    endproperty
    a_rtc: assert property (p_rtc) else $error("clock run not following supply");
endmodule
`default_nettype wire

// *** verif/test_module_power_state_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_module_power_state_sequencer import mpss_pkg::*;;
    localparam int WK = 20;
    localparam int ORD = 40;
    localparam int SL = 4;
    logic clk_i, sys_rst_i = 1'b1, main_supply_i = 1'b1, sleep_enable_i = 1'b0;
    logic fast_gpio_en_i = 1'b0, fast_gpio_i = 1'b1, power_key_wake_n_i;
    logic [9:0] c = 10'h000;
    logic [7:0] hlen = 8'h00;
    logic [31:0] rnd = 32'h0000_0000;
    logic power_on_indicator_o, cmd_accept_o, rtc_run_o, spi_en_o, spi_master_o, spi_cs_ctrl_o;
    logic [31:0] rtc_count_o;
    logic [2:0] state_o, prev_st;
    logic [2:0] exp_q[$];
    int acc_q[$];
    int cyc = 0, t, mismatches = 0, checks = 0;
    mpss_sequencer #(.WAKE_CYC(WK), .ORDERLY_CYC(ORD), .FAST_CYC(8), .SLEEP_LAT(SL), .BOOT_CYC(4))
        i_dut (.clk_i, .sys_rst_i, .ce_i(1'b1), .main_supply_i, .power_key_wake_n_i,
        .power_on_cmd_i(c[0]), .shutdown_command_i(c[1]), .fast_shutdown_command_i(c[2]),
        .uncond_shutdown_i(c[3]), .psm_enable_cmd_i(c[4]), .update_timer_expired_i(c[5]),
        .sched_wake_i(c[6]), .host_cmd_valid_i(c[7]), .rtc_set_i(c[8]), .sleep_enable_i,
        .fast_gpio_en_i, .fast_gpio_i, .spi_master_i(rnd[0]), .spi_cs_cfg_i(rnd[1]),
        .rtc_value_i(rnd), .power_on_indicator_o, .baseband_on_o(), .cmd_accept_o,
        .detach_o(), .fs_close_o(), .rtc_run_o, .rtc_count_o, .spi_en_o,
        .spi_master_o, .spi_cs_ctrl_o, .state_o);
    mpss_host_model i_host (.clk_i, .go_i(c[9]), .hold_i(hlen),
        .power_key_wake_n_o(power_key_wake_n_i));
    // --------
    // checking
    // --------
    task automatic cmp_st(input logic [2:0] g, input logic [2:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t state %0d, expected %0d", $time, g, e);
        end
    endtask
    task automatic cmp_b(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t flag %b, expected %b", $time, g, e);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_i) cyc <= cyc + 1;
    // every state change takes the oldest note; unnoted changes fail
    always @(negedge clk_i) begin
        if (!sys_rst_i && state_o !== prev_st) begin
            cmp_st(state_o, exp_q.size() > 0 ? exp_q.pop_front() : ~state_o);
            cmp_b(power_on_indicator_o, state_o inside {MPSS_BOOT, MPSS_ON, MPSS_SLEEP,
                MPSS_ORDERLY, MPSS_FAST});
        end
        if (cmd_accept_o === 1'b1) begin
            cmp_b(acc_q.size() > 0 && acc_q[0] == cyc, 1'b1);
            if (acc_q.size() > 0) void'(acc_q.pop_front());
        end
        prev_st = state_o;
    end
    // --------
    // stimulus
    // --------
    task automatic pulse(input int b);
        c[b] <= 1'b1;
        @(posedge clk_i);
        c[b] <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic act(input int b, input logic [2:0] a, input logic [2:0] z);
        int n;
        exp_q.push_back(a);
        if (z != a) exp_q.push_back(z);
        if (b >= 0) pulse(b);
        n = 0;
        while (state_o !== z && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (state_o !== z) cmp_st(state_o, z);
    endtask
    task automatic acc(input int lat);
        acc_q.push_back(cyc + 2 + lat);
        pulse(7);
        repeat (lat + 4) @(posedge clk_i);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        end_sim;
    end
    initial begin
        void'($urandom(32'hffa6));
        rnd <= $urandom;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        act(0, MPSS_BOOT, MPSS_ON);
        rnd <= $urandom;
        pulse(8);
        cmp_b(rtc_count_o === rnd, 1'b1);
        cmp_b(spi_en_o, 1'b1);
        cmp_b(spi_master_o, rnd[0]);
        cmp_b(spi_cs_ctrl_o, rnd[1]);
        acc(0);
        sleep_enable_i <= 1'b1;
        act(-1, MPSS_SLEEP, MPSS_SLEEP);
        acc(SL);
        sleep_enable_i <= 1'b0;
        act(-1, MPSS_ON, MPSS_ON);
        pulse(4);
        hlen <= 8'hff;
        pulse(9);
        act(5, MPSS_PSM, MPSS_PSM);
        cmp_b(spi_en_o, 1'b0);
        repeat (260) @(posedge clk_i);
        pulse(3);
        hlen <= 8'($urandom_range(WK - 4, 1));
        pulse(9);
        repeat (WK + 8) @(posedge clk_i);
        hlen <= 8'(WK + 4);
        act(9, MPSS_BOOT, MPSS_ON);
        act(5, MPSS_PSM, MPSS_PSM);
        act(6, MPSS_BOOT, MPSS_ON);
        t = cyc;
        act(1, MPSS_ORDERLY, MPSS_OFF);
        cmp_b(cyc - t > ORD, 1'b1);
        t = rtc_count_o;
        @(posedge clk_i);
        cmp_b(rtc_count_o === 32'(t + 1), 1'b1);
        act(0, MPSS_BOOT, MPSS_ON);
        act(2, MPSS_FAST, MPSS_OFF);
        act(0, MPSS_BOOT, MPSS_ON);
        fast_gpio_en_i <= 1'b1;
        @(posedge clk_i);
        fast_gpio_i <= 1'b0;
        act(-1, MPSS_FAST, MPSS_OFF);
        fast_gpio_i <= 1'b1;
        fast_gpio_en_i <= 1'b0;
        act(0, MPSS_BOOT, MPSS_ON);
        act(3, MPSS_HALT, MPSS_HALT);
        act(0, MPSS_BOOT, MPSS_ON);
        pulse(5);
        main_supply_i <= 1'b0;
        act(-1, MPSS_OFF, MPSS_OFF);
        @(posedge clk_i);
        cmp_b(rtc_run_o, 1'b0);
        cmp_b(rtc_count_o === 32'h0000_0000, 1'b1);
        cmp_b(acc_q.size() == 0, 1'b1);
        end_sim;
    end
endmodule
bind mpss_sequencer mpss_sequencer_checker i_chk (.clk_i, .sys_rst_i, .ce_i, .main_supply_i,
    .shutdown_command_i, .fast_shutdown_command_i, .uncond_shutdown_i, .update_timer_expired_i,
    .fast_gpio_en_i, .fast_gpio_i, .host_cmd_valid_i, .sleep_enable_i, .power_on_indicator_o,
    .baseband_on_o, .cmd_accept_o, .detach_o, .fs_close_o, .rtc_run_o, .state_o);
`default_nettype wire
